// [logic/pimen_pkg.sv]
// package for the pin interrupt mode/enable block: register map, field layout, types
// assumes a 32-bit avalon-mm word bus with byte addressing
package pimen_pkg;

    localparam int CHANNELS = 8;
    localparam int ADDR_W = 8;

    // register byte offsets
    localparam logic [7:0] OFF_MODE = 8'h00;
    localparam logic [7:0] OFF_RLE = 8'h04;
    localparam logic [7:0] OFF_RLE_SET = 8'h08;
    localparam logic [7:0] OFF_RLE_CLR = 8'h0C;
    localparam logic [7:0] OFF_FAL = 8'h10;
    localparam logic [7:0] OFF_FAL_SET = 8'h14;
    localparam logic [7:0] OFF_FAL_CLR = 8'h18;
    localparam logic [7:0] OFF_RISE = 8'h1C;
    localparam logic [7:0] OFF_FALL = 8'h20;
    localparam logic [7:0] OFF_STATUS = 8'h24;
    localparam logic [7:0] OFF_PM_CTRL = 8'h28;
    localparam logic [7:0] OFF_PM_SRC = 8'h2C;
    localparam logic [7:0] OFF_PM_CFG = 8'h30;
    localparam logic [7:0] OFF_IRQ_EN = 8'h34;
    localparam logic [7:0] OFF_IRQ_CLR = 8'h38;
    localparam logic [7:0] OFF_IRQ_STAT = 8'h3C;

    // reset values and fixed patterns
    localparam logic [7:0] CH_RESET = 8'h00;
    localparam logic [31:0] WORD_RESET = 32'h0000_0000;
    localparam logic [23:0] RSVD_ZERO = 24'h00_0000;
    localparam logic [1:0] WORD_LSB = 2'h0;

    // event status bit positions
    localparam int EV_RISE = 0;
    localparam int EV_FALL = 1;
    localparam int EV_REQ = 2;
    localparam int EV_W = 3;

    typedef logic [CHANNELS-1:0] pimen_ch_t;

    // one-hot bus slave states
    typedef enum logic [1:0] {
        ST_IDLE = 2'b01,
        ST_ACK = 2'b10
    } pimen_bus_e;

    // bus request carrier
    typedef struct packed {
        logic read;
        logic write;
        logic [ADDR_W-1:0] address;
        logic [31:0] writedata;
    } pimen_req_s;

endpackage

// [logic/pimen_top.sv]
// pin interrupt mode and rise/level enable block with its register slave
// assumes pin inputs already synchronised to clk and selected per channel
//
// Summary of operation
// - eight channels; bit n of each field governs pin-select n channel
// - mode bit 0 means edge sensitive, 1 means level sensitive
// - in edge mode the enable bit allows rising-edge interrupts
// - in level mode enable allows level interrupt, polarity from fall-level bit
// - rise/level enable field: stored 0 disables, 1 enables
// - writing ones to the set alias sets enable bits, zeros untouched
// - writing ones to the clear alias clears enable bits, zeros untouched
// - mode, enable, flag, status and match registers reset to zero
// - registers decode at word offsets 0x000 through 0x03C from base
// - fall-level bit 0 disables fall edge or selects low level; 1 the opposite
// - rising edges always recorded; request only when enabled
//
// register map, byte offsets from the block base
// channel fields sit in bits 7:0; bits above read zero
// 0x00 interrupt_mode_select, 0 edge and 1 level per channel
// 0x04 rise_level_enable, rising-edge or level enable
// 0x08 rise_level_enable_set, ones set enable bits
// 0x0C rise_level_enable_clear, ones clear enable bits
// 0x10 fall_active_level_enable, fall enable or level polarity
// 0x14 fall_active_level_set, ones set polarity or fall enable
// 0x18 fall_active_level_clear, ones clear polarity or fall enable
// 0x1C rising_edge_flags, sticky, write one to clear
// 0x20 falling_edge_flags, sticky, write one to clear
// 0x24 interrupt_status, live channel requests, writes ignored
// 0x28 match_control, storage for the match slices
// 0x2C match_slice_source, storage for the match slices
// 0x30 match_slice_config, storage for the match slices
// 0x34 event enable, bit 0 rise, bit 1 fall, bit 2 any request
// 0x38 event clear, ones clear event status bits
// 0x3C event status, sticky, read only
// set and clear aliases read zero
// any other offset reads zero and drops writes
//
// bus timing
// every access costs one wait cycle, never more, never less
// waitrequest is high in the first cycle of a request
// and low in the second, where the access is taken
// a write lands at the edge that ends the second cycle
// read data are captured at the end of the first cycle
// and stand until the next read starts
// back-to-back requests are fine, each one costs two cycles
//
// channel request paths
// edge channel: rise flag with rise enable,
// or fall flag with fall enable
// level channel: enable set and pin at the chosen polarity
// the level term is registered in level_q, then chan_irq is
// registered once more, so a level request lags the pin by two
// edges while an edge request lags its flag by one
// flags keep recording with enables off, so enabling a channel
// with a stale flag raises its request at once
//
// event interrupt
// one status bit for any rising edge, one for any falling
// edge and one for any channel request
// a new event beats a clear written in the same cycle
// irq is high while an enabled status bit is set
//
// limitations
// pin history resets low, so a pin that is high when reset
// ends looks like a rising edge and sets its flag
// the match slices only store their words here; their logic
// sits outside this block
// inputs must already be synchronous to clk
//
// The implementer's own choice: the Avalon-MM slave port.
`timescale 1ns/1ps
module pimen_top (
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // avalon-mm slave
    input wire logic [pimen_pkg::ADDR_W-1:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    // selected pin inputs, one per pin_select channel
    input wire logic [pimen_pkg::CHANNELS-1:0] pin_select_in,
    // per-channel interrupt requests and summary interrupt
    output logic [pimen_pkg::CHANNELS-1:0] chan_irq,
    output logic irq
);

    // bus carrier and slave state
    pimen_pkg::pimen_req_s req;
    pimen_pkg::pimen_bus_e bus_q;
    // channel configuration
    pimen_pkg::pimen_ch_t sensitivity_bits_q;
    pimen_pkg::pimen_ch_t rise_level_enable_bits_q;
    pimen_pkg::pimen_ch_t fall_level_bits_q;
    // edge flags, level state and pin history
    pimen_pkg::pimen_ch_t rise_q;
    pimen_pkg::pimen_ch_t fall_q;
    pimen_pkg::pimen_ch_t level_q;
    pimen_pkg::pimen_ch_t pin_q;
    // match slice storage
    logic [31:0] pm_ctrl_q;
    logic [31:0] pm_src_q;
    logic [31:0] pm_cfg_q;
    // event interrupt
    logic [pimen_pkg::EV_W-1:0] ev_en_q;
    logic [pimen_pkg::EV_W-1:0] ev_stat_q;
    // combinational helpers
    logic [31:0] rdata_d;
    logic wr_take;
    logic rd_take;
    pimen_pkg::pimen_ch_t wr_ch;
    pimen_pkg::pimen_ch_t rise_ev;
    pimen_pkg::pimen_ch_t fall_ev;
    pimen_pkg::pimen_ch_t req_ch;
    pimen_pkg::pimen_ch_t level_act;
    logic [pimen_pkg::EV_W-1:0] ev_pulse;

    // address match helper, used by every strobe and the read mux
    function automatic logic hit(input logic [pimen_pkg::ADDR_W-1:0] a,
                                 input logic [7:0] off);
        hit = (a[pimen_pkg::ADDR_W-1:2] == off[7:2]);
    endfunction

    // zero-extend a channel field to a bus word
    function automatic logic [31:0] ext(input pimen_pkg::pimen_ch_t v);
        ext = {pimen_pkg::RSVD_ZERO, v};
    endfunction

    // zero-extend the event field to a bus word
    function automatic logic [31:0] ext_ev(input logic [pimen_pkg::EV_W-1:0] v);
        ext_ev = {{(32 - pimen_pkg::EV_W){1'b0}}, v};
    endfunction

    assign req.read = avs_read;
    assign req.write = avs_write;
    assign req.address = avs_address;
    assign req.writedata = avs_writedata;

    // one wait cycle per access; the take happens in the ack state
    assign avs_waitrequest = (req.read | req.write) & (bus_q != pimen_pkg::ST_ACK);
    assign wr_take = req.write & (bus_q == pimen_pkg::ST_ACK);
    assign rd_take = req.read & (bus_q == pimen_pkg::ST_ACK);
    assign wr_ch = req.writedata[pimen_pkg::CHANNELS-1:0];

    // bus slave sequencing
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            bus_q <= pimen_pkg::ST_IDLE;
        end else begin
            case (bus_q)
                pimen_pkg::ST_IDLE: begin
                    // a request costs exactly one wait cycle
                    if (req.read | req.write) begin
                        bus_q <= pimen_pkg::ST_ACK;
                    end
                end
                pimen_pkg::ST_ACK: begin
                    // take edge; idle again for the next request
                    bus_q <= pimen_pkg::ST_IDLE;
                end
                default: begin
                    bus_q <= pimen_pkg::ST_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            sensitivity_bits_q <= pimen_pkg::CH_RESET;
        end else if (wr_take && hit(req.address, pimen_pkg::OFF_MODE)) begin
            sensitivity_bits_q <= wr_ch;
        end
    end

    // enable with set and clear aliases
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rise_level_enable_bits_q <= pimen_pkg::CH_RESET;
        end else if (wr_take) begin
            if (hit(req.address, pimen_pkg::OFF_RLE)) begin
                rise_level_enable_bits_q <= wr_ch;
            end else if (hit(req.address, pimen_pkg::OFF_RLE_SET)) begin
                rise_level_enable_bits_q <= rise_level_enable_bits_q | wr_ch;
            end else if (hit(req.address, pimen_pkg::OFF_RLE_CLR)) begin
                rise_level_enable_bits_q <= rise_level_enable_bits_q & ~wr_ch;
            end
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            fall_level_bits_q <= pimen_pkg::CH_RESET;
        end else if (wr_take) begin
            if (hit(req.address, pimen_pkg::OFF_FAL)) begin
                fall_level_bits_q <= wr_ch;
            end else if (hit(req.address, pimen_pkg::OFF_FAL_SET)) begin
                // ones select high or fall enable
                fall_level_bits_q <= fall_level_bits_q | wr_ch;
            end else if (hit(req.address, pimen_pkg::OFF_FAL_CLR)) begin
                // ones select low or fall disable
                fall_level_bits_q <= fall_level_bits_q & ~wr_ch;
            end
        end
    end

    // pattern match slice storage, held for the slices outside this block
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            pm_ctrl_q <= pimen_pkg::WORD_RESET;
            pm_src_q <= pimen_pkg::WORD_RESET;
            pm_cfg_q <= pimen_pkg::WORD_RESET;
        end else if (wr_take) begin
            // full words, read back as written
            if (hit(req.address, pimen_pkg::OFF_PM_CTRL)) begin
                pm_ctrl_q <= req.writedata;
            end
            if (hit(req.address, pimen_pkg::OFF_PM_SRC)) begin
                pm_src_q <= req.writedata;
            end
            if (hit(req.address, pimen_pkg::OFF_PM_CFG)) begin
                pm_cfg_q <= req.writedata;
            end
        end
    end

    // previous pin level for edge detection; resets low so a high pin at
    // release counts as a rising edge, which software can clear
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            pin_q <= pimen_pkg::CH_RESET;
        end else begin
            pin_q <= pin_select_in;
        end
    end

    assign rise_ev = pin_select_in & ~pin_q;
    assign fall_ev = ~pin_select_in & pin_q;

    // rising flags record regardless of enables; new edge beats clear
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rise_q <= pimen_pkg::CH_RESET;
        end else if (wr_take && hit(req.address, pimen_pkg::OFF_RISE)) begin
            // write one clears; an edge in the same cycle survives
            rise_q <= (rise_q & ~wr_ch) | rise_ev;
        end else begin
            // record every rising edge, enabled or not
            rise_q <= rise_q | rise_ev;
        end
    end

    // falling flags, same discipline
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            fall_q <= pimen_pkg::CH_RESET;
        end else if (wr_take && hit(req.address, pimen_pkg::OFF_FALL)) begin
            // write one clears; an edge in the same cycle survives
            fall_q <= (fall_q & ~wr_ch) | fall_ev;
        end else begin
            // record every falling edge, enabled or not
            fall_q <= fall_q | fall_ev;
        end
    end

    // level active when pin equals chosen polarity
    assign level_act = ~(pin_select_in ^ fall_level_bits_q);

    // level-mode status: writing one toggles the active level polarity
    // view is not modelled; status simply follows the enabled level
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            level_q <= pimen_pkg::CH_RESET;
        end else begin
            level_q <= sensitivity_bits_q & rise_level_enable_bits_q & level_act;
        end
    end

    assign req_ch = (~sensitivity_bits_q &
                     ((rise_q & rise_level_enable_bits_q) | (fall_q & fall_level_bits_q)))
                    | level_q;

    // channel requests registered for clean outputs
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            chan_irq <= pimen_pkg::CH_RESET;
        end else begin
            // one flop stage keeps the outputs glitch free
            chan_irq <= req_ch;
        end
    end

    // event enable register
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            ev_en_q <= '0;
        end else if (wr_take && hit(req.address, pimen_pkg::OFF_IRQ_EN)) begin
            ev_en_q <= req.writedata[pimen_pkg::EV_W-1:0];
        end
    end

    // event pulses at their named status positions
    always_comb begin
        ev_pulse = '0;
        ev_pulse[pimen_pkg::EV_RISE] = |rise_ev;
        ev_pulse[pimen_pkg::EV_FALL] = |fall_ev;
        ev_pulse[pimen_pkg::EV_REQ] = |req_ch;
    end

    // sticky event status; a new event wins over a clear in the same cycle
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            ev_stat_q <= '0;
        end else begin
            if (wr_take && hit(req.address, pimen_pkg::OFF_IRQ_CLR)) begin
                ev_stat_q <= (ev_stat_q & ~req.writedata[pimen_pkg::EV_W-1:0]) | ev_pulse;
            end else begin
                ev_stat_q <= ev_stat_q | ev_pulse;
            end
        end
    end

    assign irq = |(ev_stat_q & ev_en_q);

    // read mux; write-only aliases and unmapped read zero
    always_comb begin
        rdata_d = pimen_pkg::WORD_RESET;
        if (hit(req.address, pimen_pkg::OFF_MODE)) begin
            rdata_d = ext(sensitivity_bits_q);
        end else if (hit(req.address, pimen_pkg::OFF_RLE)) begin
            rdata_d = ext(rise_level_enable_bits_q);
        end else if (hit(req.address, pimen_pkg::OFF_FAL)) begin
            rdata_d = ext(fall_level_bits_q);
        end else if (hit(req.address, pimen_pkg::OFF_RISE)) begin
            rdata_d = ext(rise_q);
        end else if (hit(req.address, pimen_pkg::OFF_FALL)) begin
            rdata_d = ext(fall_q);
        end else if (hit(req.address, pimen_pkg::OFF_STATUS)) begin
            rdata_d = ext(req_ch);
        end else if (hit(req.address, pimen_pkg::OFF_PM_CTRL)) begin
            rdata_d = pm_ctrl_q;
        end else if (hit(req.address, pimen_pkg::OFF_PM_SRC)) begin
            rdata_d = pm_src_q;
        end else if (hit(req.address, pimen_pkg::OFF_PM_CFG)) begin
            rdata_d = pm_cfg_q;
        end else if (hit(req.address, pimen_pkg::OFF_IRQ_EN)) begin
            rdata_d = ext_ev(ev_en_q);
        end else if (hit(req.address, pimen_pkg::OFF_IRQ_STAT)) begin
            rdata_d = ext_ev(ev_stat_q);
        end
    end

    // read data captured in the wait cycle, stands at the release edge
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            avs_readdata <= pimen_pkg::WORD_RESET;
        end else if (req.read && bus_q == pimen_pkg::ST_IDLE) begin
            avs_readdata <= rdata_d;
        end
    end

endmodule

// [test/pimen_top_sva.sv]
// checker for pimen_top: bus timing, mode and enable readback, channel requests
// assumes it is bound to pimen_top; one clock domain
`timescale 1ns/1ps
module pimen_top_sva (
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // register bus
    input wire logic [pimen_pkg::ADDR_W-1:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [31:0] avs_readdata,
    input wire logic avs_waitrequest,
    // pins and requests
    input wire logic [pimen_pkg::CHANNELS-1:0] pin_select_in,
    input wire logic [pimen_pkg::CHANNELS-1:0] chan_irq,
    input wire logic irq
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);
    logic [7:0] mode_q;
    logic [7:0] en_q;
    logic [7:0] fl_q;
    wire req = avs_read | avs_write;
    wire take = req & ~avs_waitrequest;
    wire [5:0] word = avs_address[7:2];
    // shadow copies, so readback is judged against taken writes only
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            mode_q <= 8'h00;
            en_q <= 8'h00;
            fl_q <= 8'h00;
        end else if (take && avs_write) begin
            case (word)
                6'h00: mode_q <= avs_writedata[7:0];
                6'h01: en_q <= avs_writedata[7:0];
                6'h02: en_q <= en_q | avs_writedata[7:0];
                6'h03: en_q <= en_q & ~avs_writedata[7:0];
                6'h04: fl_q <= avs_writedata[7:0];
                6'h05: fl_q <= fl_q | avs_writedata[7:0];
                6'h06: fl_q <= fl_q & ~avs_writedata[7:0];
                default: ;
            endcase
        end
    end
    // request phases
    sequence s_req_new;
        req && !$past(req);
    endsequence
    sequence s_rd_take;
        take && avs_read;
    endsequence
    sequence s_rise0;
        $rose(pin_select_in[0]) && !mode_q[0] && en_q[0];
    endsequence
    property p_one_wait;
        s_req_new |-> avs_waitrequest ##1 !avs_waitrequest;
    endproperty
    property p_idle_nowait;
        !req |-> !avs_waitrequest;
    endproperty
    property p_reset_quiet;
        $rose(rst_n) |-> chan_irq == 8'h00 && !irq;
    endproperty
    property p_mode_read;
        s_rd_take ##0 (word == 6'h00) |-> avs_readdata == {24'h000000, mode_q};
    endproperty
    property p_rle_read;
        s_rd_take ##0 (word == 6'h01) |-> avs_readdata == {24'h000000, en_q};
    endproperty
    property p_fal_read;
        s_rd_take ##0 (word == 6'h04) |-> avs_readdata == {24'h000000, fl_q};
    endproperty
    property p_upper_zero;
        s_rd_take ##0 (word <= 6'h09) |-> avs_readdata[31:8] == 24'h000000;
    endproperty
    property p_unmapped_zero;
        s_rd_take ##0 (word > 6'h0F || word == 6'h02 || word == 6'h03) |->
            avs_readdata == 32'h00000000;
    endproperty
    property p_chan_needs_en;
        (chan_irq & ~($past(en_q) | $past(en_q, 2) | ($past(fl_q) & ~$past(mode_q)))) == 8'h00;
    endproperty
    property p_edge_rise;
        s_rise0 |-> ##[1:2] chan_irq[0];
    endproperty
    a_one_wait: assert property (p_one_wait) else $error("wait state count wrong");
    a_idle_nowait: assert property (p_idle_nowait) else $error("wait while idle");
    a_reset_quiet: assert property (p_reset_quiet) else $error("request after reset");
    a_mode_read: assert property (p_mode_read) else $error("mode readback wrong");
    a_rle_read: assert property (p_rle_read) else $error("enable readback wrong");
    a_fal_read: assert property (p_fal_read) else $error("fall level readback wrong");
    a_upper_zero: assert property (p_upper_zero) else $error("upper bits not zero");
    a_unmapped_zero: assert property (p_unmapped_zero) else $error("read not zero");
    a_chan_needs_en: assert property (p_chan_needs_en) else $error("request unenabled");
    a_edge_rise: assert property (p_edge_rise) else $error("rising edge lost");
endmodule
bind pimen_top pimen_top_sva i_sva (.clk(clk), .rst_n(rst_n), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .pin_select_in(pin_select_in), .chan_irq(chan_irq), .irq(irq));

// [test/pimen_top_test.sv]
// self-checking bench for pimen_top: registers, channel requests, event interrupt
// assumes the checker file binds itself to the design
`timescale 1ns/1ps
module pimen_top_test;
    logic clk;
    logic rst_n;
    logic [pimen_pkg::ADDR_W-1:0] avs_address;
    logic avs_read;
    logic avs_write;
    logic [31:0] avs_writedata;
    logic [31:0] avs_readdata;
    logic avs_waitrequest;
    logic [pimen_pkg::CHANNELS-1:0] pin_select_in;
    logic [pimen_pkg::CHANNELS-1:0] chan_irq;
    logic irq;
    int num_errors = 0;
    int compares = 0;
    logic [7:0] zero_offs [15] = '{8'h00, 8'h04, 8'h08, 8'h0C, 8'h10, 8'h14, 8'h18,
        8'h1C, 8'h20, 8'h24, 8'h28, 8'h2C, 8'h30, 8'h3C, 8'h40};
    pimen_top i_dut (.clk(clk), .rst_n(rst_n), .avs_address(avs_address),
        .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
        .pin_select_in(pin_select_in), .chan_irq(chan_irq), .irq(irq));
    // 20 MHz clock
    always #25 clk = ~clk;
    task final_report;
        $display("compares %0d num_errors %0d", compares, num_errors);
        if (num_errors == 0 && compares > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    task chk(input logic [31:0] seen, input logic [31:0] exp, input string what);
        compares++;
        if (seen !== exp) begin
            num_errors++;
            $display("unexpected %s expected %h seen %h", what, exp, seen);
        end
    endtask
    // request held until waitrequest is sampled low; no cycle count assumed
    task bus(input logic wr, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
        @(posedge clk);
        avs_address <= a;
        avs_read <= !wr;
        avs_write <= wr;
        avs_writedata <= d;
        do @(posedge clk); while (avs_waitrequest !== 1'b0);
        q = avs_readdata;
        avs_read <= 1'b0;
        avs_write <= 1'b0;
    endtask
    task wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] q;
        bus(1'b1, a, d, q);
    endtask
    task rchk(input logic [7:0] a, input logic [31:0] e, input string what);
        logic [31:0] q;
        bus(1'b0, a, 32'h00000000, q);
        chk(q, e, what);
    endtask
    // pin change, then room for flag and registered request
    task pins(input logic [7:0] v);
        @(posedge clk);
        pin_select_in <= v;
        repeat (4) @(posedge clk);
    endtask
    // watchdog, far beyond the few hundred cycles the tests need
    initial begin
        #200000;
        num_errors++;
        final_report();
    end
    // main sequence
    initial begin
        clk = 1'b0;
        rst_n = 1'b0;
        avs_address = 8'h00;
        avs_read = 1'b0;
        avs_write = 1'b0;
        avs_writedata = 32'h00000000;
        pin_select_in = 8'h00;
        repeat (20) @(posedge clk);
        rst_n <= 1'b1;
        foreach (zero_offs[i]) rchk(zero_offs[i], 32'h00000000, "reset read");
        wr(8'h00, 32'hFFFFFFA5);
        rchk(8'h00, 32'h000000A5, "mode");
        wr(8'h04, 32'h0F0F0F3C);
        rchk(8'h04, 32'h0000003C, "enable");
        wr(8'h08, 32'hFFFFFFC1);
        rchk(8'h04, 32'h000000FD, "enable after set");
        wr(8'h0C, 32'h0000000F);
        rchk(8'h04, 32'h000000F0, "enable after clear");
        wr(8'h40, 32'h000000FF);
        rchk(8'h04, 32'h000000F0, "enable after unmapped write");
        // edge mode: channel 0 enabled, channel 1 only recorded
        wr(8'h00, 32'h00000000);
        wr(8'h04, 32'h00000001);
        pins(8'h03);
        chk({24'h000000, chan_irq}, 32'h00000001, "edge request");
        rchk(8'h1C, 32'h00000003, "rise flags");
        wr(8'h1C, 32'h00000003);
        repeat (3) @(posedge clk);
        chk({24'h000000, chan_irq}, 32'h00000000, "request after flag clear");
        pins(8'h00);
        // level mode on channel 2, low then high active
        wr(8'h00, 32'h00000004);
        wr(8'h04, 32'h00000004);
        repeat (3) @(posedge clk);
        chk({24'h000000, chan_irq}, 32'h00000004, "low level request");
        wr(8'h14, 32'h00000004);
        repeat (3) @(posedge clk);
        chk({24'h000000, chan_irq}, 32'h00000000, "high level idle");
        rchk(8'h10, 32'h00000004, "fall level after set");
        pins(8'h04);
        chk({24'h000000, chan_irq}, 32'h00000004, "high level request");
        rchk(8'h24, 32'h00000004, "status level request");
        // summary interrupt: raise, mask, clear
        wr(8'h34, 32'h00000004);
        repeat (2) @(posedge clk);
        chk({31'h0, irq}, 32'h00000001, "irq raised");
        wr(8'h34, 32'h00000000);
        @(posedge clk);
        chk({31'h0, irq}, 32'h00000000, "irq masked");
        rchk(8'h3C, 32'h00000007, "event status");
        pins(8'h00);
        wr(8'h38, 32'h00000004);
        rchk(8'h3C, 32'h00000003, "event status cleared");
        wr(8'h34, 32'h00000004);
        @(posedge clk);
        chk({31'h0, irq}, 32'h00000000, "irq after clear");
        // fall flags, fall-level clear alias, falling-edge request, match storage
        rchk(8'h20, 32'h00000007, "fall flags");
        wr(8'h20, 32'h00000007);
        rchk(8'h20, 32'h00000000, "fall flags cleared");
        wr(8'h18, 32'h00000004);
        rchk(8'h10, 32'h00000000, "fall level after clear");
        chk({31'h0, irq}, 32'h00000001, "irq from low level");
        wr(8'h14, 32'h00000008);
        pins(8'h08);
        pins(8'h00);
        chk({24'h000000, chan_irq}, 32'h0000000C, "falling edge request");
        wr(8'h28, 32'h5A5A00FF);
        rchk(8'h28, 32'h5A5A00FF, "match control");
        // second reset in mid-run
        @(posedge clk);
        rst_n <= 1'b0;
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        rchk(8'h04, 32'h00000000, "enable after reset");
        rchk(8'h00, 32'h00000000, "mode after reset");
        chk({24'h000000, chan_irq}, 32'h00000000, "requests after reset");
        chk({31'h0, irq}, 32'h00000000, "irq after reset");
        final_report();
    end
endmodule
